// ### rtl/sam_top.sv
// Purpose: sdram multiplexed address driver for a 32-bit data bus
// Assumes: request, strobes and configuration come from same-clock logic
// Notes:   one access at a time; phase words are registered on strobe
//
// How it works
// - With two banks the single bank select rides on pin 19 in both phases.
// - With four banks pin 19 carries the low and pin 18 the high bank bit.
// - In the column phase pin 15 shows the auto-precharge choice.
// - Column pins 12..5 carry address 9..2, row pins 15..5 address 20..10.
// - The 13 row by 11 column layout places address 26,27,22,25,24,23.
// - The 13 row by 12 column layout places address 29,28,26,25,24,23.
`timescale 1ns/1ps
module sam_top (
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        CE_IN,
  input  wire logic        REQ_IN,
  input  wire logic [31:0] ADDR_IN,
  input  wire logic        AUTO_PRE_IN,
  input  wire logic [3:0]  ROW_WIDTH_IN,
  input  wire logic [3:0]  COL_WIDTH_IN,
  input  wire logic        BUS_64_IN,
  input  wire logic        ROW_STB_IN,
  input  wire logic        COL_STB_IN,
  input  wire logic        END_IN,
  output logic      [19:5] MADDR_OUT,
  output logic             ROW_PHASE_OUT,
  output logic             COL_PHASE_OUT,
  output logic             BUSY_OUT,
  output logic             MAP_OK_OUT
);

  // ****************************************************************
  // held access state
  // ****************************************************************
  sam_pkg::sam_state_type   state_reg;
  sam_pkg::sam_state_type   state_next;
  sam_pkg::sam_variant_type variant_reg;
  sam_pkg::sam_variant_type variant_next;
  logic [31:0]              addr_reg;
  logic                     pre_reg;
  logic [19:5]              row_word;
  logic [19:5]              col_word;
  logic                     take_req;

  assign take_req = CE_IN && REQ_IN && (state_reg == sam_pkg::SAM_IDLE);

  // layout select from channel setup
  always_comb begin
    variant_next = sam_pkg::SAM_VAR_NONE;
    if (!BUS_64_IN && ROW_WIDTH_IN == sam_pkg::ROW_W_13) begin
      if (COL_WIDTH_IN == sam_pkg::COL_W_11) begin
        variant_next = sam_pkg::SAM_VAR_R13C11;
      end else if (COL_WIDTH_IN == sam_pkg::COL_W_12) begin
        variant_next = sam_pkg::SAM_VAR_R13C12;
      end
    end
  end

  // access state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sam_pkg::SAM_IDLE: begin
        if (REQ_IN) begin
          state_next = sam_pkg::SAM_ACTIVE;
        end
      end
      sam_pkg::SAM_ACTIVE: begin
        if (END_IN) begin
          state_next = sam_pkg::SAM_IDLE;
        end
      end
      default: begin
        state_next = sam_pkg::SAM_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_reg <= sam_pkg::SAM_IDLE;
    end else if (CE_IN) begin
      state_reg <= state_next;
    end
  end

  // capture address and layout once per access
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      addr_reg    <= 32'h0000_0000;
      pre_reg     <= 1'b0;
      variant_reg <= sam_pkg::SAM_VAR_NONE;
    end else if (take_req) begin
      addr_reg    <= ADDR_IN;
      pre_reg     <= AUTO_PRE_IN;
      variant_reg <= variant_next;
    end
  end

  // ****************************************************************
  // mapping and pin register
  // ****************************************************************
  sam_map u_map (
    .addr_in    (addr_reg),
    .variant_in (variant_reg),
    .pre_in     (pre_reg),
    .row_out    (row_word),
    .col_out    (col_word)
  );

  // load phase word on strobe; column strobe wins if both
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      MADDR_OUT     <= sam_pkg::MADDR_RST;
      ROW_PHASE_OUT <= 1'b0;
      COL_PHASE_OUT <= 1'b0;
    end else if (CE_IN && state_reg == sam_pkg::SAM_ACTIVE) begin
      if (COL_STB_IN) begin
        MADDR_OUT     <= col_word;
        ROW_PHASE_OUT <= 1'b0;
        COL_PHASE_OUT <= 1'b1;
      end else if (ROW_STB_IN) begin
        MADDR_OUT     <= row_word;
        ROW_PHASE_OUT <= 1'b1;
        COL_PHASE_OUT <= 1'b0;
      end
    end
  end

  // status outputs
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      BUSY_OUT   <= 1'b0;
      MAP_OK_OUT <= 1'b0;
    end else if (CE_IN) begin
      BUSY_OUT <= (state_next == sam_pkg::SAM_ACTIVE);
      if (take_req) begin
        MAP_OK_OUT <= (variant_next != sam_pkg::SAM_VAR_NONE);
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic col_ld;
  logic row_ld;
  assign col_ld = CE_IN && state_reg == sam_pkg::SAM_ACTIVE && COL_STB_IN;
  assign row_ld = CE_IN && state_reg == sam_pkg::SAM_ACTIVE
                  && ROW_STB_IN && !COL_STB_IN;

  property p_bank_low;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    (row_ld || col_ld) && variant_reg == sam_pkg::SAM_VAR_R13C11
    |=> MADDR_OUT[19] == $past(addr_reg[26]);
  endproperty
  a_bank_low: assert property (p_bank_low)
    else $error("bank select low pin wrong");

  property p_bank_pair;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    (row_ld || col_ld) && variant_reg == sam_pkg::SAM_VAR_R13C12
    |=> MADDR_OUT[19:18] == {$past(addr_reg[29]), $past(addr_reg[28])};
  endproperty
  a_bank_pair: assert property (p_bank_pair)
    else $error("bank select pair wrong");

  property p_precharge;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    col_ld |=> COL_PHASE_OUT && MADDR_OUT[15] == $past(pre_reg);
  endproperty
  a_precharge: assert property (p_precharge)
    else $error("precharge level wrong");

  property p_common;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    (col_ld |=> MADDR_OUT[12:5] == $past(addr_reg[9:2]))
    and (row_ld |=> ROW_PHASE_OUT
         && MADDR_OUT[15:5] == $past(addr_reg[20:10]));
  endproperty
  a_common: assert property (p_common)
    else $error("common address bits wrong");

  property p_c11;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    col_ld && variant_reg == sam_pkg::SAM_VAR_R13C11
    |=> {MADDR_OUT[18:16], MADDR_OUT[14:13]} == {$past(addr_reg[27]),
        $past(addr_reg[22]), $past(addr_reg[25:23])};
  endproperty
  a_c11: assert property (p_c11)
    else $error("13x11 column layout wrong");

  property p_c12;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    row_ld && variant_reg == sam_pkg::SAM_VAR_R13C12
    |=> MADDR_OUT[17:16] == $past(addr_reg[22:21]);
  endproperty
  a_c12: assert property (p_c12)
    else $error("13x12 row layout wrong");

  property p_hold;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    state_reg == sam_pkg::SAM_ACTIVE ##1 state_reg == sam_pkg::SAM_ACTIVE
    |-> $stable(variant_reg) && $stable(addr_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("access setup changed mid access");

  // upper row pins of the 13x11 layout
  property p_c11_row;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    row_ld && variant_reg == sam_pkg::SAM_VAR_R13C11
    |=> MADDR_OUT[18:16] == {$past(addr_reg[27]), $past(addr_reg[22:21])};
  endproperty
  a_c11_row: assert property (p_c11_row)
    else $error("13x11 row layout wrong");

  // upper column pins of the 13x12 layout
  property p_c12_col;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    col_ld && variant_reg == sam_pkg::SAM_VAR_R13C12
    |=> {MADDR_OUT[17:16], MADDR_OUT[14:13]} == $past(addr_reg[26:23]);
  endproperty
  a_c12_col: assert property (p_c12_col)
    else $error("13x12 column layout wrong");

  // an unsupported setup drives no layout bits and flags it
  property p_no_layout;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
    (row_ld || col_ld) && variant_reg == sam_pkg::SAM_VAR_NONE
    |=> MADDR_OUT[19:16] == 4'h0 && !MAP_OK_OUT;
  endproperty
  a_no_layout: assert property (p_no_layout)
    else $error("unknown layout drove upper pins");

endmodule : sam_top

// ### common/sam_pkg.sv
// Purpose: shared constants for the sdram address multiplexer
// Assumes: 32-bit data bus mapping, pins 19 down to 5
// Notes:   address bit numbers are processor byte address positions
package sam_pkg;

  // ****************************************************************
  // widths and configuration codes
  // ****************************************************************
  localparam int unsigned PIN_HI   = 19;
  localparam int unsigned PIN_LO   = 5;
  localparam int unsigned ADDR_W   = 32;
  localparam logic [3:0]  ROW_W_13 = 4'hd;
  localparam logic [3:0]  COL_W_11 = 4'hb;
  localparam logic [3:0]  COL_W_12 = 4'hc;

  // ****************************************************************
  // pin positions
  // ****************************************************************
  localparam int unsigned PIN_BANK_LOW  = 19;  // bank_select_low
  localparam int unsigned PIN_BANK_HIGH = 18;  // bank_select_high
  localparam int unsigned PIN_17        = 17;
  localparam int unsigned PIN_16        = 16;
  localparam int unsigned PIN_PRE       = 15;  // auto_precharge_line
  localparam int unsigned PIN_14        = 14;
  localparam int unsigned PIN_13        = 13;
  localparam int unsigned COL_PIN_TOP   = 12;  // common column pins 12..5
  localparam int unsigned ROW_PIN_TOP   = 15;  // common row pins 15..5
  localparam int unsigned COL_ADDR_LOW  = 2;   // column pin 5 <- addr 2
  localparam int unsigned ROW_ADDR_LOW  = 10;  // row pin 5 <- addr 10

  // ****************************************************************
  // 13 row / 11 column variant: address sources per pin
  // ****************************************************************
  localparam int unsigned V11_C19 = 26;
  localparam int unsigned V11_C18 = 27;
  localparam int unsigned V11_C17 = 22;
  localparam int unsigned V11_C16 = 25;
  localparam int unsigned V11_C14 = 24;
  localparam int unsigned V11_C13 = 23;
  localparam int unsigned V11_R17 = 22;
  localparam int unsigned V11_R16 = 21;

  // ****************************************************************
  // 13 row / 12 column variant: address sources per pin
  // ****************************************************************
  localparam int unsigned V12_C19 = 29;
  localparam int unsigned V12_C18 = 28;
  localparam int unsigned V12_C17 = 26;
  localparam int unsigned V12_C16 = 25;
  localparam int unsigned V12_C14 = 24;
  localparam int unsigned V12_C13 = 23;
  localparam int unsigned V12_R17 = 22;
  localparam int unsigned V12_R16 = 21;

  // ****************************************************************
  // reset values and types
  // ****************************************************************
  localparam logic [14:0] MADDR_RST = 15'h0000;

  typedef enum logic [1:0] {
    SAM_VAR_NONE,
    SAM_VAR_R13C11,
    SAM_VAR_R13C12
  } sam_variant_type;

  typedef enum logic {
    SAM_IDLE,
    SAM_ACTIVE
  } sam_state_type;

endpackage : sam_pkg

// ### rtl/sam_map.sv
// Purpose: builds row and column pin words from a held address
// Assumes: inputs are stable registers of the same clock
// Notes:   pure combinational mapping, registered by the parent
`timescale 1ns/1ps
module sam_map (
  input  wire logic [31:0]              addr_in,
  input  wire sam_pkg::sam_variant_type variant_in,
  input  wire logic                     pre_in,
  output logic      [19:5]              row_out,
  output logic      [19:5]              col_out
);

  // ****************************************************************
  // common bits, one generate loop per phase
  // ****************************************************************
  // common bits live apart so each output word has a single driver
  logic [12:5] col_base;
  logic [15:5] row_base;

  genvar i;
  generate
    for (i = sam_pkg::PIN_LO; i <= sam_pkg::COL_PIN_TOP; i++) begin : g_col
      assign col_base[i] = addr_in[i - sam_pkg::PIN_LO
                                   + sam_pkg::COL_ADDR_LOW];
    end
    for (i = sam_pkg::PIN_LO; i <= sam_pkg::ROW_PIN_TOP; i++) begin : g_row
      assign row_base[i] = addr_in[i - sam_pkg::PIN_LO
                                   + sam_pkg::ROW_ADDR_LOW];
    end
  endgenerate

  // ****************************************************************
  // variant bits: bank selects and upper pins
  // ****************************************************************
  always_comb begin
    col_out                   = 15'h0000;
    row_out                   = 15'h0000;
    col_out[12:5]             = col_base;
    row_out[15:5]             = row_base;
    col_out[sam_pkg::PIN_PRE] = pre_in;  // precharge level, column only
    case (variant_in)
      sam_pkg::SAM_VAR_R13C11: begin
        col_out[sam_pkg::PIN_BANK_LOW]  = addr_in[sam_pkg::V11_C19];
        col_out[sam_pkg::PIN_BANK_HIGH] = addr_in[sam_pkg::V11_C18];
        col_out[sam_pkg::PIN_17]        = addr_in[sam_pkg::V11_C17];
        col_out[sam_pkg::PIN_16]        = addr_in[sam_pkg::V11_C16];
        col_out[sam_pkg::PIN_14]        = addr_in[sam_pkg::V11_C14];
        col_out[sam_pkg::PIN_13]        = addr_in[sam_pkg::V11_C13];
        row_out[sam_pkg::PIN_BANK_LOW]  = addr_in[sam_pkg::V11_C19];
        row_out[sam_pkg::PIN_BANK_HIGH] = addr_in[sam_pkg::V11_C18];
        row_out[sam_pkg::PIN_17]        = addr_in[sam_pkg::V11_R17];
        row_out[sam_pkg::PIN_16]        = addr_in[sam_pkg::V11_R16];
      end
      sam_pkg::SAM_VAR_R13C12: begin
        col_out[sam_pkg::PIN_BANK_LOW]  = addr_in[sam_pkg::V12_C19];
        col_out[sam_pkg::PIN_BANK_HIGH] = addr_in[sam_pkg::V12_C18];
        col_out[sam_pkg::PIN_17]        = addr_in[sam_pkg::V12_C17];
        col_out[sam_pkg::PIN_16]        = addr_in[sam_pkg::V12_C16];
        col_out[sam_pkg::PIN_14]        = addr_in[sam_pkg::V12_C14];
        col_out[sam_pkg::PIN_13]        = addr_in[sam_pkg::V12_C13];
        row_out[sam_pkg::PIN_BANK_LOW]  = addr_in[sam_pkg::V12_C19];
        row_out[sam_pkg::PIN_BANK_HIGH] = addr_in[sam_pkg::V12_C18];
        row_out[sam_pkg::PIN_17]        = addr_in[sam_pkg::V12_R17];
        row_out[sam_pkg::PIN_16]        = addr_in[sam_pkg::V12_R16];
      end
      default: begin
        col_out[19:16] = 4'h0;
      end
    endcase
  end

endmodule : sam_map

// ### sim/sam_sdram_model.sv
// Purpose: memory side model that latches the words seen on its pins
// Assumes: phase flags tell which word the pins carry after a strobe
// Notes:   passive; the memory drives nothing back to the multiplexer
`timescale 1ns/1ps
module sam_sdram_model (
  input  wire logic        clk_in,
  input  wire logic [19:5] maddr_in,
  input  wire logic        row_phase_in,
  input  wire logic        col_phase_in,
  output logic      [19:5] row_word_out,
  output logic      [19:5] col_word_out
);
  // ******************************************************************
  // pin capture
  // ******************************************************************
  // latch the activate word and the read or write word like a device
  always_ff @(posedge clk_in) begin
    if (row_phase_in) begin
      row_word_out <= maddr_in;
    end
    if (col_phase_in) begin
      col_word_out <= maddr_in;
    end
  end
endmodule : sam_sdram_model

// ### sim/sam_top_test.sv
// Purpose: self-checking bench for the sdram address multiplexer
// Assumes: request, strobe and end timing as the design hands over
// Notes:   walking-one addresses for each layout, then awkward cases
`timescale 1ns/1ps
module sam_top_test;
  // ******************************************************************
  // signals and case table
  // ******************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic        pre;
    logic [3:0]  row_w;
    logic [3:0]  col_w;
    logic        bus_64;
    logic [19:5] exp_row;
    logic [19:5] exp_col;
    logic        exp_ok;
  } sam_case_type;
  logic         clk     = 1'b0;
  logic         rst_n   = 1'b0;
  logic         ce      = 1'b1;
  logic         req     = 1'b0;
  logic         pre     = 1'b0;
  logic         b64     = 1'b0;
  logic         row_stb = 1'b0;
  logic         col_stb = 1'b0;
  logic         fin     = 1'b0;
  logic [31:0]  addr    = 32'h0;
  logic [3:0]   row_w   = 4'hd;
  logic [3:0]   col_w   = 4'hb;
  logic [19:5]  maddr;
  logic [19:5]  seen_row;
  logic [19:5]  seen_col;
  logic         row_ph;
  logic         col_ph;
  logic         busy;
  logic         map_ok;
  logic [18:0]  outs;
  int           error_cnt = 0;
  int           tests_run = 0;
  sam_case_type rows [150];

  // all outputs in one word for the reset checks
  assign outs = {maddr, row_ph, col_ph, busy, map_ok};

  // free-running 25 MHz clock
  always #20 clk = ~clk;

  sam_top sam_top_i (.CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
    .REQ_IN(req), .ADDR_IN(addr), .AUTO_PRE_IN(pre), .ROW_WIDTH_IN(row_w),
    .COL_WIDTH_IN(col_w), .BUS_64_IN(b64), .ROW_STB_IN(row_stb),
    .COL_STB_IN(col_stb), .END_IN(fin), .MADDR_OUT(maddr),
    .ROW_PHASE_OUT(row_ph), .COL_PHASE_OUT(col_ph), .BUSY_OUT(busy),
    .MAP_OK_OUT(map_ok));

  sam_sdram_model sam_sdram_model_i (.clk_in(clk), .maddr_in(maddr),
    .row_phase_in(row_ph), .col_phase_in(col_ph),
    .row_word_out(seen_row), .col_word_out(seen_col));

  // ******************************************************************
  // helpers
  // ******************************************************************
  // expected pin word; layout 0 is 13x11, 1 is 13x12, 2 has none
  function automatic logic [19:5] ref_word(input logic [31:0] a,
      input logic p, input int v, input logic col);
    logic [19:5] w;
    w = 15'h0000;
    if (col) begin
      w[12:5] = a[9:2];
      w[15] = p;
      if (v == 0) begin
        {w[19], w[18], w[17], w[16], w[14], w[13]} =
          {a[26], a[27], a[22], a[25], a[24], a[23]};
      end else if (v == 1) begin
        {w[19], w[18], w[17], w[16], w[14], w[13]} =
          {a[29], a[28], a[26], a[25], a[24], a[23]};
      end
    end else begin
      w[15:5] = a[20:10];
      if (v == 0) begin
        w[19:16] = {a[26], a[27], a[22], a[21]};
      end else if (v == 1) begin
        w[19:16] = {a[29], a[28], a[22], a[21]};
      end
    end
    return w;
  endfunction : ref_word

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic set_in(input sam_case_type c);
    addr  = c.addr;
    pre   = c.pre;
    row_w = c.row_w;
    col_w = c.col_w;
    b64   = c.bus_64;
  endtask : set_in

  // full access; mid-access all inputs but row width flip and a request is repeated
  task automatic run_access(input sam_case_type c);
    @(negedge clk);
    set_in(c);
    req = 1'b1;
    @(negedge clk);
    {addr, pre, col_w, b64} = ~{c.addr, c.pre, c.col_w, c.bus_64};
    row_stb = 1'b1;
    chk(busy, 1'b1);
    chk(map_ok, c.exp_ok);
    @(negedge clk);
    row_stb = 1'b0;
    col_stb = 1'b1;
    chk(maddr, c.exp_row);
    chk(row_ph, 1'b1);
    @(negedge clk);
    col_stb = 1'b0;
    fin = 1'b1;
    chk(maddr, c.exp_col);
    chk(seen_row, c.exp_row);
    chk({row_ph, col_ph}, 2'b01);
    @(negedge clk);
    fin = 1'b0;
    req = 1'b0;
    chk(busy, 1'b0);
    chk(seen_col, c.exp_col);
  endtask : run_access

  task automatic end_of_test;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // ******************************************************************
  // stimulus
  // ******************************************************************
  // watchdog well beyond the expected run of about 770 cycles
  initial begin
    #(3000 * 40);
    error_cnt++;
    end_of_test();
  end

  // table build, reset, table loop, then awkward cases
  initial begin
    for (int v = 0; v < 5; v++) begin
      for (int b = 0; b < 30; b++) begin
        rows[v*30+b].addr   = 32'h1 << (b + 2);
        rows[v*30+b].pre    = b[0];
        rows[v*30+b].row_w  = (v == 4) ? 4'hc : 4'hd;
        rows[v*30+b].col_w  = (v == 1) ? 4'hc : (v == 2) ? 4'ha : 4'hb;
        rows[v*30+b].bus_64 = (v == 3);
        rows[v*30+b].exp_ok = (v < 2);
        rows[v*30+b].exp_row = ref_word(rows[v*30+b].addr, b[0],
                                        (v < 2) ? v : 2, 1'b0);
        rows[v*30+b].exp_col = ref_word(rows[v*30+b].addr, b[0],
                                        (v < 2) ? v : 2, 1'b1);
      end
    end
    repeat (8) @(negedge clk);
    chk(outs, {sam_pkg::MADDR_RST, 4'h0});
    rst_n = 1'b1;
    foreach (rows[i]) begin
      run_access(rows[i]);
    end
    // a request with the clock enable low is not taken
    @(negedge clk);
    ce  = 1'b0;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    ce  = 1'b1;
    chk(busy, 1'b0);
    // a row strobe while idle leaves the pins alone
    row_stb = 1'b1;
    @(negedge clk);
    row_stb = 1'b0;
    chk(maddr, rows[149].exp_col);
    chk(row_ph, 1'b0);
    // column strobe wins when both strobes come together
    set_in(rows[57]);
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    {row_stb, col_stb} = 2'b11;
    @(negedge clk);
    {row_stb, col_stb} = 2'b00;
    chk(maddr, rows[57].exp_col);
    chk({row_ph, col_ph}, 2'b01);
    // reset in mid-access clears every output, then a clean access
    rst_n = 1'b0;
    #1;
    chk(outs, {sam_pkg::MADDR_RST, 4'h0});
    @(negedge clk);
    rst_n = 1'b1;
    // address bit 26 shows on the bank-low pin in both phases
    run_access(rows[24]);
    end_of_test();
  end
endmodule : sam_top_test
